// ==== core/nfb_pkg.sv ====
// Package with constants and types for the parallel NOR flash host controller.
package nfb_pkg;

  // ****************************************************************
  // Timing.
  // ****************************************************************
  localparam int CLK_NS = 10;
  localparam int ACC_NS = 70;
  localparam int ACC_CYC = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_NS = 35;
  localparam int WP_CYC = (WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WH_NS = 20;
  localparam int WH_CYC = (WH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RP_NS = 500;
  localparam int RP_CYC = (RP_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_OP_LSB = 1;
  localparam int CTRL_WORD_BIT = 4;
  localparam int CTRL_HV_BIT = 5;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam logic WORD_MODE_RST = 1'h1;
  localparam logic HV_RST = 1'h0;
  localparam logic [22:0] ADDR_RST = 23'h0;
  localparam logic [15:0] WDATA_RST = 16'h0;

  // ****************************************************************
  // Command codes and command addresses.
  // ****************************************************************
  localparam logic [7:0] CMD_UNLOCK1 = 8'haa;
  localparam logic [7:0] CMD_UNLOCK2 = 8'h55;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_PROGRAM = 8'ha0;
  localparam logic [7:0] CMD_RESET = 8'hf0;
  localparam logic [7:0] CMD_CFI = 8'h98;
  localparam logic [11:0] UNL1_WORD = 12'h555;
  localparam logic [11:0] UNL2_WORD = 12'h2aa;
  localparam logic [11:0] UNL1_BYTE = 12'haaa;
  localparam logic [11:0] UNL2_BYTE = 12'h555;
  localparam logic [11:0] CFI_WORD = 12'h055;
  localparam logic [11:0] CFI_BYTE = 12'h0aa;
  localparam int POLL_BIT = 7;

  // ****************************************************************
  // Types.
  // ****************************************************************
  typedef enum logic [2:0] {
    OP_READ = 3'h0,
    OP_PROGRAM = 3'h1,
    OP_IDENT = 3'h2,
    OP_RESET = 3'h3,
    OP_CFI = 3'h4,
    OP_HWRESET = 3'h5
  } nfb_op_t;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic [21:0] addr;
    logic [15:0] dq_out;
    logic [15:0] dq_oe;
  } nfb_pins_t;

  typedef struct packed {
    logic write;
    logic [22:0] addr;
    logic [15:0] data;
  } nfb_req_t;

endpackage : nfb_pkg

// ==== core/nfb_cycle.sv ====
// Single flash bus cycle engine: one read or one write on the flash pins.
`timescale 1ns/1ps
`default_nettype none
module nfb_cycle #(
  parameter int ACC_CYC = nfb_pkg::ACC_CYC,
  parameter int WP_CYC = nfb_pkg::WP_CYC,
  parameter int WH_CYC = nfb_pkg::WH_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_start,
  input wire nfb_pkg::nfb_req_t i_req,
  input wire logic i_word_mode,
  input wire logic [15:0] i_dq,
  output logic o_idle,
  output logic o_done,
  output logic [15:0] o_rdata,
  output nfb_pkg::nfb_pins_t o_pins
);

  typedef enum logic [2:0] {
    C_IDLE, C_SETUP, C_STROBE, C_SAMPLE, C_RECOVER
  } nfb_cstate_t;

  localparam nfb_pkg::nfb_pins_t PINS_IDLE = '{1'b1, 1'b1, 1'b1,
    22'h0, 16'h0, 16'h0};

  nfb_cstate_t state, next_state;
  nfb_pkg::nfb_pins_t pins, next_pins;
  logic [7:0] cnt, next_cnt;
  logic write, next_write;
  logic done, next_done;
  logic [15:0] rdata, next_rdata;
  logic [15:0] s1, s2, s3;

  // ****************************************************************
  // Data line synchroniser.
  // ****************************************************************
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1 <= 16'h0;
      s2 <= 16'h0;
      s3 <= 16'h0;
    end else begin
      s1 <= i_dq;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // ****************************************************************
  // Cycle sequencing.
  // ****************************************************************
  always_comb begin
    next_state = state;
    next_pins = pins;
    next_cnt = cnt;
    next_write = write;
    next_done = 1'b0;
    next_rdata = rdata;
    case (state)
      C_IDLE: begin
        if (i_start) begin
          next_write = i_req.write;
          next_pins.ce_n = 1'b0;
          next_pins.dq_out = 16'h0;
          next_pins.dq_oe = 16'h0;
          if (i_word_mode) begin
            next_pins.addr = i_req.addr[21:0];
            if (i_req.write) begin
              next_pins.dq_out = i_req.data;
              next_pins.dq_oe = 16'hffff;
            end
          end else begin
            next_pins.addr = i_req.addr[22:1];
            next_pins.dq_out[15] = i_req.addr[0];
            next_pins.dq_oe[15] = 1'b1;
            if (i_req.write) begin
              next_pins.dq_out[7:0] = i_req.data[7:0];
              next_pins.dq_oe[7:0] = 8'hff;
            end
          end
          next_state = C_SETUP;
        end
      end
      C_SETUP: begin
        if (write) begin
          next_pins.we_n = 1'b0;
          next_cnt = 8'(WP_CYC - 1);
        end else begin
          next_pins.oe_n = 1'b0;
          next_cnt = 8'(ACC_CYC - 1);
        end
        next_state = C_STROBE;
      end
      C_STROBE: begin
        if (cnt != 8'h0) begin
          next_cnt = cnt - 8'h1;
        end else if (write) begin
          next_pins.we_n = 1'b1;
          next_pins.ce_n = 1'b1;
          next_cnt = 8'(WH_CYC - 1);
          next_state = C_RECOVER;
        end else begin
          next_state = C_SAMPLE;
        end
      end
      C_SAMPLE: begin
        if (i_word_mode ? (s2 == s3) : (s2[7:0] == s3[7:0])) begin
          next_rdata = i_word_mode ? s3 : {8'h0, s3[7:0]};
          next_pins.oe_n = 1'b1;
          next_pins.ce_n = 1'b1;
          next_cnt = 8'(WH_CYC - 1);
          next_state = C_RECOVER;
        end
      end
      C_RECOVER: begin
        if (cnt != 8'h0) begin
          next_cnt = cnt - 8'h1;
        end else begin
          next_pins = PINS_IDLE;
          next_done = 1'b1;
          next_state = C_IDLE;
        end
      end
      default: begin
        next_pins = PINS_IDLE;
        next_state = C_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= C_IDLE;
      pins <= PINS_IDLE;
      cnt <= 8'h0;
      write <= 1'b0;
      done <= 1'b0;
      rdata <= 16'h0;
    end else begin
      state <= next_state;
      pins <= next_pins;
      cnt <= next_cnt;
      write <= next_write;
      done <= next_done;
      rdata <= next_rdata;
    end
  end

  assign o_idle = (state == C_IDLE);
  assign o_done = done;
  assign o_rdata = rdata;
  assign o_pins = pins;

endmodule : nfb_cycle
`default_nettype wire

// ==== core/nfb_host.sv ====
// Host controller that drives a parallel NOR flash from Wishbone registers.
//
// Overview of operation
// - Read: chip-select and output-enable low, write strobe high.
// - Elevated-voltage identification uses address bits 0, 1, 6, bank; the flash model decodes bits 0, 1 and 12 and ignores the bank.
// - Command identification: two unlocks, then 90H at bank address.
// - Third write and fourth read use the same bank address.
// - Identification lasts until the reset command is written.
// - Write: address on later falling, data on earlier rising strobe.
// - Program is two unlocks, setup command, then address and data.
`timescale 1ns/1ps
`default_nettype none
module nfb_host #(
  parameter int ACC_CYC = nfb_pkg::ACC_CYC,
  parameter int WP_CYC = nfb_pkg::WP_CYC,
  parameter int WH_CYC = nfb_pkg::WH_CYC,
  parameter int RP_CYC = nfb_pkg::RP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic [15:0] i_flash_dq,
  output nfb_pkg::nfb_pins_t o_flash,
  output logic o_flash_word_mode,
  output logic o_flash_hv_id,
  output logic o_flash_reset_n
);

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT, S_HWRST} nfb_state_t;

  // ****************************************************************
  // Command sequence helpers.
  // ****************************************************************
  function automatic logic [22:0] with_bank(input logic word_mode,
      input logic [11:0] base, input logic [22:0] ua);
    if (word_mode) begin
      with_bank = {1'b0, ua[21:20], 8'h0, base};
    end else begin
      with_bank = {ua[22:21], 9'h0, base};
    end
  endfunction : with_bank

  function automatic logic [2:0] last_step(input nfb_pkg::nfb_op_t op);
    case (op)
      nfb_pkg::OP_PROGRAM: last_step = 3'h4;
      nfb_pkg::OP_IDENT: last_step = 3'h3;
      default: last_step = 3'h0;
    endcase
  endfunction : last_step

  function automatic nfb_pkg::nfb_req_t step_req(
      input nfb_pkg::nfb_op_t op, input logic [2:0] step,
      input logic wm, input logic [22:0] ua, input logic [15:0] wd);
    logic [11:0] u1;
    logic [11:0] u2;
    u1 = wm ? nfb_pkg::UNL1_WORD : nfb_pkg::UNL1_BYTE;
    u2 = wm ? nfb_pkg::UNL2_WORD : nfb_pkg::UNL2_BYTE;
    step_req = '{1'b0, ua, 16'h0};
    case (op)
      nfb_pkg::OP_PROGRAM, nfb_pkg::OP_IDENT: begin
        case (step)
          3'h0: step_req = '{1'b1, with_bank(wm, u1, ua),
                             {8'h0, nfb_pkg::CMD_UNLOCK1}};
          3'h1: step_req = '{1'b1, with_bank(wm, u2, ua),
                             {8'h0, nfb_pkg::CMD_UNLOCK2}};
          3'h2: step_req = '{1'b1, with_bank(wm, u1, ua), {8'h0,
                             (op == nfb_pkg::OP_IDENT) ? nfb_pkg::CMD_IDENT
                             : nfb_pkg::CMD_PROGRAM}};
          3'h3: step_req = '{op == nfb_pkg::OP_PROGRAM, ua, wd};
          default: step_req = '{1'b0, ua, 16'h0};
        endcase
      end
      nfb_pkg::OP_RESET:
        step_req = '{1'b1, ua, {8'h0, nfb_pkg::CMD_RESET}};
      nfb_pkg::OP_CFI:
        step_req = '{1'b1, with_bank(wm, wm ? nfb_pkg::CFI_WORD
                     : nfb_pkg::CFI_BYTE, ua), {8'h0, nfb_pkg::CMD_CFI}};
      default: step_req = '{1'b0, ua, 16'h0};
    endcase
  endfunction : step_req

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = sel[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction : merge

  // ****************************************************************
  // Registers and sequencer.
  // ****************************************************************
  nfb_state_t state, next_state;
  nfb_pkg::nfb_op_t op, next_op;
  logic [2:0] step, next_step;
  logic word_mode, next_word_mode;
  logic hv_id, next_hv_id;
  logic [22:0] addr, next_addr;
  logic [15:0] wdata, next_wdata;
  logic [15:0] rdata, next_rdata;
  logic busy, next_busy;
  logic done, next_done;
  logic reset_n, next_reset_n;
  logic [15:0] rcnt, next_rcnt;
  logic ack, next_ack;
  logic [31:0] dat, next_dat;
  logic start, cyc_idle, cyc_done;
  logic [15:0] cyc_rdata;
  logic wr_acc;
  logic [31:0] ctrl_val, wr_val;
  nfb_pkg::nfb_req_t req;
  nfb_pkg::nfb_op_t wr_op;

  assign wr_acc = i_wb_cyc && i_wb_stb && i_wb_we && ack;
  assign ctrl_val = {26'h0, hv_id, word_mode, op, 1'b0};
  assign req = step_req(op, step, word_mode, addr, wdata);
  assign start = (state == S_ISSUE) && cyc_idle;

  always_comb begin
    next_state = state;
    next_op = op;
    next_step = step;
    next_word_mode = word_mode;
    next_hv_id = hv_id;
    next_addr = addr;
    next_wdata = wdata;
    next_rdata = rdata;
    next_busy = busy;
    next_done = done;
    next_reset_n = reset_n;
    next_rcnt = rcnt;
    next_ack = i_wb_cyc && i_wb_stb && !ack;
    next_dat = 32'h0;
    wr_val = merge(ctrl_val, i_wb_dat, i_wb_sel);
    wr_op = nfb_pkg::nfb_op_t'(wr_val[nfb_pkg::CTRL_OP_LSB +: 3]);
    case (i_wb_adr)
      nfb_pkg::REG_CTRL: next_dat = ctrl_val;
      nfb_pkg::REG_ADDR: next_dat = {9'h0, addr};
      nfb_pkg::REG_WDATA: next_dat = {16'h0, wdata};
      nfb_pkg::REG_RDATA: next_dat = {16'h0, rdata};
      nfb_pkg::REG_STATUS: next_dat = {30'h0, done, busy};
      default: next_dat = 32'h0;
    endcase
    if (wr_acc && !busy) begin
      case (i_wb_adr)
        nfb_pkg::REG_CTRL: begin
          next_word_mode = wr_val[nfb_pkg::CTRL_WORD_BIT];
          next_hv_id = wr_val[nfb_pkg::CTRL_HV_BIT];
          next_op = wr_op;
        end
        nfb_pkg::REG_ADDR:
          next_addr = 23'(merge({9'h0, addr}, i_wb_dat, i_wb_sel));
        nfb_pkg::REG_WDATA:
          next_wdata = 16'(merge({16'h0, wdata}, i_wb_dat, i_wb_sel));
        default: begin
        end
      endcase
    end
    if (wr_acc && i_wb_adr == nfb_pkg::REG_STATUS && i_wb_sel[0] &&
        i_wb_dat[nfb_pkg::STAT_DONE_BIT]) begin
      next_done = 1'b0;
    end
    case (state)
      S_IDLE: begin
        if (wr_acc && i_wb_adr == nfb_pkg::REG_CTRL && i_wb_sel[0] &&
            i_wb_dat[nfb_pkg::CTRL_GO_BIT]) begin
          next_busy = 1'b1;
          next_step = 3'h0;
          if (wr_op == nfb_pkg::OP_HWRESET) begin
            next_state = S_HWRST;
            next_reset_n = 1'b0;
            next_rcnt = 16'(RP_CYC - 1);
          end else begin
            next_state = S_ISSUE;
          end
        end
      end
      S_ISSUE: begin
        if (cyc_idle) begin
          next_state = S_WAIT;
        end
      end
      S_WAIT: begin
        if (cyc_done) begin
          if (!req.write) begin
            next_rdata = cyc_rdata;
          end
          if (step != last_step(op)) begin
            next_step = step + 3'h1;
            next_state = S_ISSUE;
          end else if (op == nfb_pkg::OP_PROGRAM &&
              cyc_rdata[nfb_pkg::POLL_BIT] != wdata[nfb_pkg::POLL_BIT]) begin
            next_state = S_ISSUE;
          end else begin
            next_state = S_IDLE;
            next_busy = 1'b0;
            next_done = 1'b1;
          end
        end
      end
      S_HWRST: begin
        if (rcnt != 16'h0) begin
          next_rcnt = rcnt - 16'h1;
        end else begin
          next_reset_n = 1'b1;
          next_state = S_IDLE;
          next_busy = 1'b0;
          next_done = 1'b1;
        end
      end
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state <= S_IDLE;
      op <= nfb_pkg::OP_READ;
      step <= 3'h0;
      word_mode <= nfb_pkg::WORD_MODE_RST;
      hv_id <= nfb_pkg::HV_RST;
      addr <= nfb_pkg::ADDR_RST;
      wdata <= nfb_pkg::WDATA_RST;
      rdata <= 16'h0;
      busy <= 1'b0;
      done <= 1'b0;
      reset_n <= 1'b1;
      rcnt <= 16'h0;
      ack <= 1'b0;
      dat <= 32'h0;
    end else begin
      state <= next_state;
      op <= next_op;
      step <= next_step;
      word_mode <= next_word_mode;
      hv_id <= next_hv_id;
      addr <= next_addr;
      wdata <= next_wdata;
      rdata <= next_rdata;
      busy <= next_busy;
      done <= next_done;
      reset_n <= next_reset_n;
      rcnt <= next_rcnt;
      ack <= next_ack;
      dat <= next_dat;
    end
  end

  // ****************************************************************
  // Flash bus cycle engine.
  // ****************************************************************
  nfb_cycle #(
    .ACC_CYC(ACC_CYC),
    .WP_CYC(WP_CYC),
    .WH_CYC(WH_CYC)
  ) u_cycle (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_start(start),
    .i_req(req),
    .i_word_mode(word_mode),
    .i_dq(i_flash_dq),
    .o_idle(cyc_idle),
    .o_done(cyc_done),
    .o_rdata(cyc_rdata),
    .o_pins(o_flash)
  );

  assign o_wb_ack = ack;
  assign o_wb_dat = dat;
  assign o_flash_word_mode = word_mode;
  assign o_flash_hv_id = hv_id;
  assign o_flash_reset_n = reset_n;

endmodule : nfb_host
`default_nettype wire

// ==== dv/nfb_flash_model.sv ====
// Behavioural parallel NOR flash device facing the host controller.
`timescale 1ns/1ps
`default_nettype none
module nfb_flash_model #(
  parameter int PROG_NS = 400,
  parameter logic [15:0] MAKER_ID = 16'h0000,
  parameter logic [15:0] DEVICE_ID = 16'h0000
) (
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_word,
  input wire logic i_hv,
  input wire logic i_reset_n,
  input wire logic [21:0] i_addr,
  input wire logic [15:0] i_dq,
  output logic [15:0] o_dq,
  output logic [15:0] o_oe
);
  // ****************************************************************
  // Command decoder, program routine and read path.
  // ****************************************************************
  logic [15:0] mem [0:255];
  logic [15:0] pd, w;
  logic [21:0] wa;
  logic [11:0] ca, u1, u2;
  logic [7:0] d, pa;
  logic [1:0] st, bank, pbank;
  logic ident, busy, bs, wsel, pb7;
  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 16'hffff;
    st = 2'h0;
    ident = 1'b0;
    busy = 1'b0;
  end
  assign u1 = i_word ? 12'h555 : 12'haaa;
  assign u2 = i_word ? 12'h2aa : 12'h555;
  always @(negedge i_we_n) begin
    wa = i_addr;
    bs = i_dq[15];
    wsel = !i_ce_n && i_oe_n;
    ca = i_word ? {1'b0, i_addr[10:0]} : {i_addr[10:0], i_dq[15]};
  end
  always @(posedge i_we_n or negedge i_reset_n) begin
    d = i_dq[7:0];
    if (!i_reset_n) begin
      st = 2'h0;
      ident = 1'b0;
      busy = 1'b0;
    end else if (!busy && wsel) begin
      if (st == 2'h3) begin
        pa = wa[7:0];
        pbank = wa[21:20];
        pb7 = i_dq[7];
        pd = i_word ? i_dq : bs ? {d, 8'hff} : {8'hff, d};
        st = 2'h0;
        busy = 1'b1;
      end else if (d == 8'hf0) begin
        st = 2'h0;
        ident = 1'b0;
      end else if (st == 2'h0 && d == 8'haa && ca == u1) st = 2'h1;
      else if (st == 2'h1 && d == 8'h55 && ca == u2) st = 2'h2;
      else if (st == 2'h2 && d == 8'h90 &&
          ca == u1) begin
        st = 2'h0;
        ident = 1'b1;
        bank = wa[21:20];
      end else if (st == 2'h2 && d == 8'ha0 && ca == u1) st = 2'h3;
      else if (d != 8'h98) st = 2'h0;
    end
  end
  always @(posedge busy) begin
    #(PROG_NS);
    if (busy) mem[pa] = mem[pa] & pd;
    busy = 1'b0;
  end
  always_comb begin
    if (busy && i_addr[21:20] == pbank) w = {2{~pb7, 7'h00}};
    else if (i_hv || (ident && i_addr[21:20] == bank)) begin
      case (i_addr[1:0])
        2'h0: w = MAKER_ID;
        2'h1: w = DEVICE_ID;
        2'h2: w = {15'h0, i_addr[12]};
        default: w = 16'h0080;
      endcase
    end else w = mem[i_addr[7:0]];
    o_oe = 16'h0000;
    if (!i_ce_n && !i_oe_n && i_we_n) begin
      o_oe = i_word ? 16'hffff : 16'h00ff;
    end
    o_dq = (i_word || !i_dq[15]) ? w : {8'h00, w[15:8]};
  end
endmodule : nfb_flash_model
`default_nettype wire

// ==== dv/nfb_host_asserts.sv ====
// Checker of the flash host controller port behaviour.
`timescale 1ns/1ps
`default_nettype none
module nfb_host_asserts #(
  parameter int RP_CYC = nfb_pkg::RP_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] o_wb_dat,
  input wire logic o_wb_ack,
  input wire nfb_pkg::nfb_pins_t o_flash,
  input wire logic o_flash_word_mode,
  input wire logic o_flash_reset_n
);
  // ****************************************************************
  // Reset pulse counter and port properties.
  // ****************************************************************
  logic [7:0] low_cnt;
  logic [7:0] next_low_cnt;
  always_comb begin
    next_low_cnt = o_flash_reset_n ? 8'h00 : low_cnt + 8'h01;
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      low_cnt <= 8'h00;
    end else begin
      low_cnt <= next_low_cnt;
    end
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  ack_pulse_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack held longer than one cycle");
  ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack
    |=> o_wb_ack) else $error("ack missing one cycle after request");
  unmapped_zero_a: assert property (o_wb_ack && !i_wb_we && i_wb_adr > 8'h10
    |-> o_wb_dat == 32'h0) else $error("unmapped read not zero");
  read_strobe_a: assert property (!o_flash.oe_n |->
    !o_flash.ce_n && o_flash.we_n && o_flash.dq_oe[14:0] == 15'h0)
    else $error("bad read");
  write_strobe_a: assert property (!o_flash.we_n |->
    !o_flash.ce_n && o_flash.oe_n && o_flash.dq_oe[7:0] == 8'hff)
    else $error("bad write");
  data_hold_a: assert property ($rose(o_flash.we_n) |->
    o_flash.dq_oe[7:0] == 8'hff && $stable(o_flash.dq_out))
    else $error("write data not held at strobe rise");
  pulse_width_a: assert property ($fell(o_flash.we_n) |->
    (!o_flash.we_n)[*4] ##1 o_flash.we_n) else $error("write pulse width");
  word_lines_a: assert property (o_flash_word_mode && !o_flash.we_n
    |-> o_flash.dq_oe == 16'hffff) else $error("word write lines");
  byte_lines_a: assert property (!o_flash_word_mode &&
    !o_flash.ce_n |-> o_flash.dq_oe[15] && o_flash.dq_oe[14:8] == 7'h0)
    else $error("byte mode lines");
  reset_pulse_a: assert property ($rose(o_flash_reset_n)
    |-> int'(low_cnt) == RP_CYC) else $error("reset pulse length");
  reset_quiet_a: assert property (!o_flash_reset_n
    |-> o_flash.ce_n && o_flash.we_n) else $error("cycle during reset");
endmodule : nfb_host_asserts
bind nfb_host nfb_host_asserts #(.RP_CYC(RP_CYC)) u_asserts (
  .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
  .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .o_wb_dat(o_wb_dat),
  .o_wb_ack(o_wb_ack), .o_flash(o_flash),
  .o_flash_word_mode(o_flash_word_mode), .o_flash_reset_n(o_flash_reset_n)
);
`default_nettype wire

// ==== dv/nfb_host_bench.sv ====
// Self-checking bench for the flash host controller.
`timescale 1ns/1ps
`default_nettype none
module nfb_host_bench;
  // ****************************************************************
  // Bench signals, design, device model and bus resolution.
  // ****************************************************************
  localparam logic [15:0] MAKER_ID = 16'h005a; // Arbitrary value.
  localparam logic [15:0] DEVICE_ID = 16'h3c96; // Arbitrary value.
  localparam logic [31:0] ALL = 32'hffffffff;
  localparam logic [31:0] LOW = 32'h0000ffff;
  typedef struct packed {
    logic [31:0] v;
    logic [31:0] m;
  } nfb_exp_t;
  logic i_clk, i_rst, cyc, stb, we, o_wb_ack, word_mode, hv_id, reset_n;
  logic [7:0] adr, w, b;
  logic [31:0] wdat, o_wb_dat, q;
  logic [22:0] a;
  logic [15:0] dq, dq_last, m_dq, m_oe, rnd, d;
  logic [15:0] shadow [0:255];
  logic [15:0] idv [0:3];
  nfb_pkg::nfb_pins_t pins;
  nfb_exp_t e;
  nfb_exp_t exp_q [$];
  int fails, total_checks, cycles;
  nfb_host #(.RP_CYC(2)) u_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_flash_dq(dq),
    .o_flash(pins), .o_flash_word_mode(word_mode),
    .o_flash_hv_id(hv_id), .o_flash_reset_n(reset_n)
  );
  nfb_flash_model #(.MAKER_ID(MAKER_ID), .DEVICE_ID(DEVICE_ID)) u_flash (
    .i_ce_n(pins.ce_n), .i_oe_n(pins.oe_n), .i_we_n(pins.we_n),
    .i_word(word_mode), .i_hv(hv_id), .i_reset_n(reset_n),
    .i_addr(pins.addr), .i_dq(dq), .o_dq(m_dq), .o_oe(m_oe)
  );
  assign dq = (pins.dq_oe & pins.dq_out) | (m_oe & m_dq) |
    (~pins.dq_oe & ~m_oe & ~dq_last);
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task automatic wb(input logic wr, input logic [7:0] ad,
                    input logic [31:0] v);
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= ad;
    wdat <= v;
    do @(posedge i_clk); while (o_wb_ack !== 1'b1);
    q = o_wb_dat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic rd(input logic [7:0] ad, input logic [31:0] v,
                    input logic [31:0] m);
    exp_q.push_back('{v, m});
    wb(1'b0, ad, 32'h0);
  endtask : rd
  task automatic op(input logic [2:0] c, input logic [22:0] ad,
                    input logic [15:0] v, input logic [1:0] md);
    wb(1'b1, nfb_pkg::REG_ADDR, {9'h0, ad});
    wb(1'b1, nfb_pkg::REG_WDATA, {16'h0, v});
    wb(1'b1, nfb_pkg::REG_CTRL, {26'h0, md, c, 1'b1});
    q = 32'h0;
    while (q[1] !== 1'b1) rd(nfb_pkg::REG_STATUS, 32'h0, 32'h0);
    wb(1'b1, nfb_pkg::REG_STATUS, 32'h2);
  endtask : op
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_sim
  always @(posedge i_clk) begin
    dq_last <= dq;
    cycles++;
    if (cycles == 60000) begin
      fails++;
      end_sim();
    end
    if (o_wb_ack === 1'b1 && we === 1'b0 && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      if (e.m != 32'h0) begin
        total_checks++;
        if ((o_wb_dat & e.m) !== e.v) begin
          fails++;
          $display("ERROR read %h expected %h seen %h", adr, e.v, o_wb_dat);
        end
      end
    end
  end
  initial begin
    {cyc, stb, we, adr, wdat, dq_last, fails, total_checks, cycles} = '0;
    i_rst = 1'b1;
    rnd = 16'haa67;
    idv = '{MAKER_ID, DEVICE_ID, 16'h0001, 16'h0080};
    for (int i = 0; i < 256; i++) shadow[i] = 16'hffff;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(nfb_pkg::REG_CTRL, 32'h10, ALL);
    wb(1'b1, 8'h14, ALL);
    rd(8'h14, 32'h0, ALL);
    for (int i = 0; i < 3; i++) begin
      rnd = lfsr(rnd);
      w = rnd[15:8];
      a = {1'b0, rnd[1:0], 12'h0, w};
      for (int j = 0; j < 2; j++) begin
        rnd = lfsr(rnd);
        d = {rnd[15:8], shadow[w][7], rnd[6:0]};
        shadow[w] = shadow[w] & d;
        op(3'h1, a, d, 2'h1);
        op(3'h0, a, 16'h0, 2'h1);
        rd(nfb_pkg::REG_RDATA, {16'h0, shadow[w]}, LOW);
      end
    end
    for (int k = 0; k < 4; k++) begin
      op(3'h2, {10'h0, k[1], 10'h0, k[1:0]}, 16'h0,
         2'h1);
      rd(nfb_pkg::REG_RDATA, {16'h0, idv[k]},
         LOW);
    end
    op(3'h0, 23'h0, 16'h0, 2'h1);
    rd(nfb_pkg::REG_RDATA, {16'h0, MAKER_ID}, LOW);
    op(3'h3, 23'h0, 16'h0, 2'h1);
    op(3'h0, a, 16'h0, 2'h1);
    rd(nfb_pkg::REG_RDATA, {16'h0, shadow[w]}, LOW);
    op(3'h0, 23'h1002, 16'h0, 2'h3);
    rd(nfb_pkg::REG_RDATA, 32'h1, LOW);
    rnd = lfsr(rnd);
    b = {shadow[w][7], rnd[6:0]};
    shadow[w][7:0] = shadow[w][7:0] & b;
    op(3'h1, {a[21:0], 1'b0}, {8'h0, b}, 2'h0);
    for (int k = 0; k < 2; k++) begin
      op(3'h0, {a[21:0], k[0]}, 16'h0, 2'h0);
      rd(nfb_pkg::REG_RDATA, {24'h0, shadow[w][8*k +: 8]}, LOW);
    end
    op(3'h4, 23'h0, 16'h0, 2'h1);
    op(3'h2, a, 16'h0, 2'h1);
    op(3'h5, 23'h0, 16'h0, 2'h1);
    op(3'h0, a, 16'h0, 2'h1);
    rd(nfb_pkg::REG_RDATA, {16'h0, shadow[w]}, LOW);
    rd(nfb_pkg::REG_STATUS, 32'h0, ALL);
    end_sim();
  end
endmodule : nfb_host_bench
`default_nettype wire
